// ==== tes_pkg.sv ====
`default_nettype none
// ****************************************************************
// Shared constants for the transmit gate select block.
// ****************************************************************
package tes_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Register offsets.
    localparam logic [11:0] OFS_HALF_LSB = 12'h02EA;
    localparam logic [11:0] OFS_GATE_SEL = 12'h02F8;
    localparam logic [11:0] OFS_GATE_BITS = 12'h02F9;
    localparam logic [11:0] OFS_STATUS = 12'h02FA;
    // Reset values.
    localparam logic [7:0] RST_HALF_LSB = 8'h00;
    localparam logic [7:0] RST_GATE_SEL = 8'h03;
    localparam logic [7:0] RST_GATE_BITS = 8'h03;
    // Field positions.
    localparam int BIT_HALF_LSB = 0;
    localparam int BIT_SRC_A = 0;
    localparam int BIT_SRC_B = 1;
    localparam int BIT_FAST_GATE = 2;
    localparam int BIT_LOW_NOISE = 3;
    localparam int BIT_GATE_A = 0;
    localparam int BIT_GATE_B = 1;
    // Datapath widths.
    localparam int SAMPLE_W = 16;
    localparam int OUT_W = 12;
    // Extra latency of the low-noise mute path, in DAC clocks.
    localparam int QUIET_LAT = 56;
    // Pipeline fill delay after clocks restart before data is valid.
    localparam int WAKE_CYCLES = 8;
    // Static aging-safe code inserted after element matching.
    localparam logic [11:0] SAFE_CODE = 12'h0800;
endpackage : tes_pkg
`default_nettype wire

// ==== tes_delay_line.sv ====
`default_nettype none
// ****************************************************************
// Fixed-length delay line of single-bit flags.
// ****************************************************************
module tes_delay_line #(
    parameter int DEPTH = 56
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    logic [DEPTH-1:0] pipe_r;
    logic [DEPTH-1:0] pipe_nxt;

    // Shift one place each cycle.
    always_comb begin
        pipe_nxt = {pipe_r[DEPTH-2:0], din};
    end

    // Reset clears the line so a stale enable never leaks out.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pipe_r <= '0;
        end else begin
            pipe_r <= pipe_nxt;
        end
    end

    assign dout = pipe_r[DEPTH-1];
endmodule // tes_delay_line
`default_nettype wire

// ==== tes_gate_ctrl.sv ====
// The strobed register port was left to the implementer.
`default_nettype none
// Summary of operation
// R1: Half-LSB offset added before truncation below 16 bits.
// R2: Change offset register only while datapath stopped.
// R3: Mute clear: disabled output is static safe code.
// R4: Mute set: mute element matching input, 56 clocks.
// R5: Mute select only with fast gate set.
// R6: Power-save mode: both off stops link clocks.
// R7: After wake, outputs muted until data valid.
// R8: Fast gate: no clock stop, channels independent.
// R9: Channel B source zero: follow pin.
// R10: Channel B source one: follow register bit.
// R11: Channel A source zero: follow pin.
// R12: Channel A source one: follow register bit.
// R13: Software keeps both source bits equal.
// R14: Gate bits at 0x2F9, both reset one.
// R15: Reserved bits read back, no effect.
module tes_gate_ctrl (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [tes_pkg::ADDR_W-1:0] regAddr,
    input wire logic [tes_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [tes_pkg::DATA_W-1:0] regRdata,
    input wire logic datapathRun,
    input wire logic chanAGatePin,
    input wire logic chanBGatePin,
    input wire logic [tes_pkg::SAMPLE_W-1:0] sampleA,
    input wire logic [tes_pkg::SAMPLE_W-1:0] sampleB,
    output logic [tes_pkg::OUT_W-1:0] outputChannelA,
    output logic [tes_pkg::OUT_W-1:0] outputChannelB,
    output logic linkClkEn,
    output logic chanATxOn,
    output logic chanBTxOn
);
    import tes_pkg::*;

    // ****************************************************************
    // Register file
    // ****************************************************************
    // All three registers keep full bytes; the status word is built, not stored,
    // so it costs no flops and can never disagree with the state it reports.
    logic [7:0] halfLsb_r, halfLsb_nxt;
    logic [7:0] gateSel_r, gateSel_nxt;
    logic [7:0] gateBits_r, gateBits_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] statusWord;

    // Full-byte storage keeps reserved bits readable but unused.
    // A write lands on the edge that samples the strobe; an unmapped or
    // read-only offset drops it without notice.
    always_comb begin
        halfLsb_nxt = halfLsb_r;
        gateSel_nxt = gateSel_r;
        gateBits_nxt = gateBits_r;
        if (regWr) begin
            unique case (regAddr)
                OFS_HALF_LSB: halfLsb_nxt = regWdata; // [R15]
                OFS_GATE_SEL: gateSel_nxt = regWdata; // [R15]
                OFS_GATE_BITS: gateBits_nxt = regWdata; // [R14]
                default: ;
            endcase
        end
    end

    // Read data are valid the cycle after the strobe; unmapped reads give zero.
    // Zero outside the read slot lets the data be ORed with other banks.
    always_comb begin
        rdata_nxt = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                OFS_HALF_LSB: rdata_nxt = halfLsb_r;
                OFS_GATE_SEL: rdata_nxt = gateSel_r;
                OFS_GATE_BITS: rdata_nxt = gateBits_r;
                OFS_STATUS: rdata_nxt = statusWord;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Reset restores the power-on values; otherwise the next values are taken.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            halfLsb_r <= RST_HALF_LSB;
            gateSel_r <= RST_GATE_SEL;
            gateBits_r <= RST_GATE_BITS;
            rdata_r <= 8'h00;
        end else begin
            halfLsb_r <= halfLsb_nxt;
            gateSel_r <= gateSel_nxt;
            gateBits_r <= gateBits_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign regRdata = rdata_r;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] pinMeta_r, pinMeta_nxt, pinSync_r, pinSync_nxt;
    logic runMeta_r, runMeta_nxt, runSync_r, runSync_nxt;

    // Gate pins and the run level come from outside this clock domain,
    // so each passes two flops before any logic looks at it.
    // Only the second stage is ever read; the first may be metastable.
    always_comb begin
        pinMeta_nxt = {chanBGatePin, chanAGatePin};
        pinSync_nxt = pinMeta_r;
        runMeta_nxt = datapathRun;
        runSync_nxt = runMeta_r;
    end

    // Clearing the stages on reset keeps a stale pin level out of the first enable.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pinMeta_r <= 2'h0;
            pinSync_r <= 2'h0;
            runMeta_r <= 1'b0;
            runSync_r <= 1'b0;
        end else begin
            pinMeta_r <= pinMeta_nxt;
            pinSync_r <= pinSync_nxt;
            runMeta_r <= runMeta_nxt;
            runSync_r <= runSync_nxt;
        end
    end

    // ****************************************************************
    // Transmit enable selection
    // ****************************************************************
    // A source bit of one selects the register gate bit; zero selects the pin.
    // Pins are used after the synchroniser, so a pin change reaches the enables two edges later.
    logic fastGate, lowNoise, enA, enB;
    // Software must keep the two source bits equal; each is honoured as written.
    assign enA = gateSel_r[BIT_SRC_A] ? gateBits_r[BIT_GATE_A] // [R12]
                                      : pinSync_r[0]; // [R11]
    assign enB = gateSel_r[BIT_SRC_B] ? gateBits_r[BIT_GATE_B] // [R10]
                                      : pinSync_r[1]; // [R9]
    assign fastGate = gateSel_r[BIT_FAST_GATE];
    // Low-noise mute only takes effect alongside fast gate.
    assign lowNoise = gateSel_r[BIT_LOW_NOISE] & fastGate; // [R5]

    // ****************************************************************
    // Power-save sequencer
    // ****************************************************************
    // RUN passes data, SLEEP holds the clocks off, WAKE waits for the refill.
    // One-hot codes; the default arm recovers from an illegal code.
    typedef enum logic [2:0] {
        PS_RUN = 3'b001,
        PS_SLEEP = 3'b010,
        PS_WAKE = 3'b100
    } tes_ps_e;
    tes_ps_e psState_r, psState_nxt;
    logic [3:0] wakeCnt_r, wakeCnt_nxt;
    logic clkEn_r, clkEn_nxt;

    // Stopping the clocks saves power but costs a refill on wake-up.
    always_comb begin
        psState_nxt = psState_r;
        wakeCnt_nxt = wakeCnt_r;
        unique case (psState_r)
            PS_RUN: begin
                // Both enables off with fast gate clear sends the clocks to sleep.
                if (!fastGate && !enA && !enB) begin
                    psState_nxt = PS_SLEEP; // [R6]
                end
            end
            PS_SLEEP: begin
                // Any live enable, or fast gate, restarts the clocks.
                if (fastGate || enA || enB) begin
                    psState_nxt = PS_WAKE;
                    wakeCnt_nxt = 4'(WAKE_CYCLES - 1);
                end
            end
            PS_WAKE: begin
                // The count covers the pipeline refill; muting lasts until it runs out.
                if (!fastGate && !enA && !enB) begin
                    psState_nxt = PS_SLEEP;
                end else if (wakeCnt_r == 4'h0) begin
                    psState_nxt = PS_RUN; // [R7]
                end else begin
                    wakeCnt_nxt = wakeCnt_r - 4'h1;
                end
            end
            default: psState_nxt = PS_RUN;
        endcase
        // Fast gate never stops a clock.
        // Clocks come back on the same edge that the sequencer leaves SLEEP.
        clkEn_nxt = (psState_nxt != PS_SLEEP) || fastGate; // [R8]
    end

    // Reset starts in RUN with the clocks on, matching the reset enables.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            psState_r <= PS_RUN;
            wakeCnt_r <= 4'h0;
            clkEn_r <= 1'b1;
        end else begin
            psState_r <= psState_nxt;
            wakeCnt_r <= wakeCnt_nxt;
            clkEn_r <= clkEn_nxt;
        end
    end
    assign linkClkEn = clkEn_r;

    // ****************************************************************
    // Datapath: half-LSB rounding and muting
    // ****************************************************************
    // Per-channel signals are indexed by channel: 0 is channel A, 1 is channel B.
    logic [1:0] enQuiet;
    logic [OUT_W-1:0] outA_r, outA_nxt, outB_r, outB_nxt;
    logic [1:0] txOn_r, txOn_nxt;
    logic [1:0] enLive;
    logic [SAMPLE_W-1:0] smp [2];
    logic [OUT_W-1:0] outNxt [2];
    // Rounding offset: half of the lowest kept bit, bit DROP-1 of the sample.
    localparam int DROP = SAMPLE_W - OUT_W;
    localparam logic [SAMPLE_W-1:0] HALF = SAMPLE_W'(1) << (DROP - 1);

    // Gather the per-channel inputs so the generate loop can index them.
    // The samples share this clock and need no synchroniser.
    assign enLive = {enB, enA};
    assign smp[0] = sampleA;
    assign smp[1] = sampleB;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : gChan
            logic [SAMPLE_W-1:0] rounded;
            logic gateOn;
            // Low-noise path adds a fixed delay on the enable.
            // The line is cleared by reset, so a channel starts disabled on that path.
            tes_delay_line #(.DEPTH(QUIET_LAT)) uQuiet (
                .core_clk(core_clk),
                .srst(srst),
                .din(enLive[ch]),
                .dout(enQuiet[ch])
            );
            // Saturate rather than wrap when the offset overflows full scale.
            always_comb begin
                rounded = smp[ch];
                if (halfLsb_r[BIT_HALF_LSB] && (smp[ch] < ~HALF)) begin
                    rounded = smp[ch] + HALF; // [R1]
                end
                // On the low-noise path the delayed enable gates the data, so the
                // mute lifts only once the extra latency has passed.
                gateOn = (lowNoise ? enQuiet[ch] : enLive[ch]) // [R4]
                         && (psState_r == PS_RUN); // [R7]
                // Both mute kinds hold mid-scale; they differ only in where the mute acts.
                if (!gateOn) begin
                    outNxt[ch] = lowNoise ? {1'b1, {(OUT_W-1){1'b0}}} // [R4]
                                          : SAFE_CODE; // [R3]
                end else begin
                    outNxt[ch] = rounded[SAMPLE_W-1 -: OUT_W];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Every output pin leaves a flop. The transmit-on flags report the
    // selected enable rather than the mute, so they lead the data on wake-up.
    always_comb begin
        outA_nxt = outNxt[0];
        outB_nxt = outNxt[1];
        txOn_nxt = enLive;
    end

    // Reset parks both outputs on the safe code with transmission off.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            outA_r <= SAFE_CODE;
            outB_r <= SAFE_CODE;
            txOn_r <= 2'h0;
        end else begin
            outA_r <= outA_nxt;
            outB_r <= outB_nxt;
            txOn_r <= txOn_nxt;
        end
    end
    assign outputChannelA = outA_r;
    assign outputChannelB = outB_r;
    assign chanATxOn = txOn_r[0];
    assign chanBTxOn = txOn_r[1];

    // ****************************************************************
    // Status word
    // ****************************************************************
    // Read-only view of the run level, sequencer state and live enables.
    // Bits 7 to 5 are unused and read as zero.
    assign statusWord = {
        3'h0,
        runSync_r,
        psState_r == PS_RUN,
        psState_r == PS_SLEEP,
        enB,
        enA
    };
endmodule // tes_gate_ctrl
`default_nettype wire

// ==== tes_gate_ctrl_props.sv ====
`default_nettype none
// ****
// Port checks for the gate select block.
// ****
module tes_gate_ctrl_props (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [tes_pkg::ADDR_W-1:0] regAddr,
    input wire logic [tes_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [tes_pkg::DATA_W-1:0] regRdata,
    input wire logic chanAGatePin,
    input wire logic chanBGatePin,
    input wire logic [tes_pkg::OUT_W-1:0] outputChannelA,
    input wire logic linkClkEn,
    input wire logic chanATxOn,
    input wire logic chanBTxOn
);
    timeunit 1ns;
    timeprecision 1ns;
    import tes_pkg::*;
    logic [7:0] sel_r, sel_nxt, bits_r, bits_nxt;
    logic [1:0] pins, txOn;
    logic muted, selRd;
    // Mirror what software wrote, since the checks judge against it.
    always_comb begin
        sel_nxt = (regWr && regAddr == OFS_GATE_SEL) ? regWdata : sel_r;
        bits_nxt = (regWr && regAddr == OFS_GATE_BITS) ? regWdata : bits_r;
    end
    always_ff @(posedge core_clk) begin
        sel_r <= srst ? RST_GATE_SEL : sel_nxt;
        bits_r <= srst ? RST_GATE_BITS : bits_nxt;
    end
    // Short names keep each check on one line.
    assign pins = {chanBGatePin, chanAGatePin};
    assign txOn = {chanBTxOn, chanATxOn};
    assign muted = outputChannelA == SAFE_CODE;
    assign selRd = regRd && regAddr == OFS_GATE_SEL;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (srst);
    // Held long enough to cross the pin sync and the output flop.
    sequence pinsHeld;
        (sel_r[1:0] == 2'b00 && $stable(pins))[*4];
    endsequence
    sequence bitsHeld;
        (sel_r[1:0] == 2'b11 && $stable(bits_r))[*3];
    endsequence
    sequence slowIdle;
        (!sel_r[BIT_FAST_GATE] && !chanATxOn && !chanBTxOn)[*3];
    endsequence
    sequence offPlain;
        (!chanATxOn && !sel_r[BIT_LOW_NOISE])[*2];
    endsequence
    pin_gate_a: assert property (pinsHeld |-> txOn == pins)
        else $error("enables do not follow the pins");
    reg_gate_a: assert property (bitsHeld |-> txOn == bits_r[1:0])
        else $error("enables do not follow the gate bits");
    clock_stop_a: assert property (slowIdle |-> !linkClkEn)
        else $error("clocks run with both channels off");
    fast_run_a: assert property (sel_r[BIT_FAST_GATE] [*3] |-> linkClkEn)
        else $error("clocks stopped in fast gate mode");
    safe_code_a: assert property (offPlain |-> muted)
        else $error("disabled output is not the safe code");
    wake_mute_a: assert property ($rose(linkClkEn) |-> muted [*4])
        else $error("output not muted after wake");
    read_back_a: assert property (selRd |=> regRdata == sel_r)
        else $error("gate select read back wrong");
    read_idle_a: assert property (!regRd |=> regRdata == '0)
        else $error("read data outside the read slot");
endmodule // tes_gate_ctrl_props
bind tes_gate_ctrl tes_gate_ctrl_props chk (.core_clk, .srst, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .chanAGatePin, .chanBGatePin, .outputChannelA, .linkClkEn,
    .chanATxOn, .chanBTxOn);
`default_nettype wire

// ==== tes_host_model.sv ====
`default_nettype none
// ****
// Host side: drives the two gate pins.
// ****
module tes_host_model #(
    parameter int LAG = 1
) (
    input wire logic core_clk,
    input wire logic wantA,
    input wire logic wantB,
    output logic chanAGatePin,
    output logic chanBGatePin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lagA = '0;
    logic [7:0] lagB = '0;
    // A slow host moves its pins LAG edges after it decides to.
    always @(posedge core_clk) begin
        lagA <= {lagA[6:0], wantA};
        lagB <= {lagB[6:0], wantB};
    end
    // Plain levels; the two pins may step apart.
    assign chanAGatePin = lagA[LAG-1];
    assign chanBGatePin = lagB[LAG-1];
endmodule // tes_host_model
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
// ****
// Testbench for the transmit gate select block.
// ****
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tes_pkg::*;
    localparam logic [11:0] ADRS[4] = '{OFS_HALF_LSB, OFS_GATE_SEL, OFS_GATE_BITS, 12'h0123};
    localparam logic [7:0] RSTS[4] = '{RST_HALF_LSB, RST_GATE_SEL, RST_GATE_BITS, 8'h00};
    localparam logic [7:0] MODES[3] = '{8'h00, 8'h04, 8'h0C};
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic datapathRun = 1'b0;
    logic wantA = 1'b1;
    logic wantB = 1'b1;
    logic rdDly = 1'b0;
    logic [15:0] sampleA = '0;
    logic [15:0] sampleB = '0;
    logic [DATA_W-1:0] regRdata;
    logic [OUT_W-1:0] outputChannelA, outputChannelB;
    logic chanAGatePin, chanBGatePin, linkClkEn, chanATxOn, chanBTxOn;
    logic [7:0] expQ[$];
    logic [31:0] rnd = 32'h0000_4201;
    int mismatches = 0;
    int cmp_count = 0;
    tes_gate_ctrl dut (.core_clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .datapathRun, .chanAGatePin, .chanBGatePin, .sampleA, .sampleB, .outputChannelA,
        .outputChannelB, .linkClkEn, .chanATxOn, .chanBTxOn);
    tes_host_model #(.LAG(2)) host (.core_clk, .wantA, .wantB, .chanAGatePin, .chanBGatePin);
    // Half period of the 20 MHz clock.
    always #25 core_clk = ~core_clk;
    // Read data stand one cycle only, so the oldest note is matched right then.
    always @(posedge core_clk) begin
        logic [7:0] e;
        rdDly <= regRd;
        if (rdDly) begin
            e = expQ.pop_front();
            `CHK("regRdata", e, regRdata)
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Each access leaves a gap so a strobe is never driven twice in one step.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset values, offset rounding, register gating, gating modes.
    initial begin
        logic [7:0] v;
        logic [16:0] sum, sumB;
        logic ok;
        int lat;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        wr(12'h0123, 8'hFF);
        for (int i = 0; i < 4; i++) rd(ADRS[i], RSTS[i]);
        for (int h = 0; h < 2; h++) begin
            datapathRun <= 1'b0;
            rnd = lfsr(rnd);
            v = {rnd[7:1], h[0]};
            repeat (4) @(posedge core_clk);
            wr(OFS_HALF_LSB, v);
            rd(OFS_HALF_LSB, v);
            datapathRun <= 1'b1;
            repeat (4) begin
                rnd = lfsr(rnd);
                sampleA <= rnd[15:0];
                sampleB <= rnd[31:16];
                repeat (4) @(posedge core_clk);
                sum = {1'b0, rnd[15:0]} + (h ? 17'h0008 : 17'h0000);
                sumB = {1'b0, rnd[31:16]} + (h ? 17'h0008 : 17'h0000);
                `CHK("outputChannelA", sum[16] ? 12'hFFF : sum[15:4], outputChannelA)
                `CHK("outputChannelB", sumB[16] ? 12'hFFF : sumB[15:4], outputChannelB)
            end
        end
        sampleA <= 16'h1234;
        wr(OFS_GATE_SEL, 8'hF3);
        rd(OFS_GATE_SEL, 8'hF3);
        wr(OFS_GATE_BITS, 8'h00);
        repeat (6) @(posedge core_clk);
        `CHK("chanATxOn", 1'b0, chanATxOn)
        `CHK("chanBTxOn", 1'b0, chanBTxOn)
        `CHK("linkClkEn", 1'b0, linkClkEn)
        rd(OFS_STATUS, 8'h14);
        wr(OFS_GATE_BITS, 8'h03);
        repeat (4) @(posedge core_clk);
        `CHK("chanATxOn", 1'b1, chanATxOn)
        for (int k = 0; k < 3; k++) begin
            wr(OFS_GATE_SEL, MODES[k]);
            wantA <= 1'b0;
            wantB <= 1'b0;
            repeat (80) @(posedge core_clk);
            `CHK("linkClkEn", MODES[k][BIT_FAST_GATE], linkClkEn)
            `CHK("outputChannelA", SAFE_CODE, outputChannelA)
            wantA <= 1'b1;
            for (lat = 0; lat < 300 && outputChannelA === SAFE_CODE; lat++) @(posedge core_clk);
            if (lat == 300) begin
                mismatches++;
                close_out();
            end
            ok = k == 0 ? lat > WAKE_CYCLES : k == 1 ? lat < WAKE_CYCLES : lat > QUIET_LAT;
            `CHK("latency", 1'b1, ok)
            `CHK("chanATxOn", 1'b1, chanATxOn)
            `CHK("chanBTxOn", 1'b0, chanBTxOn)
        end
        close_out();
    end
endmodule // tb
`default_nettype wire
